// >>> verilog/vpic_top.sv
// Register core, bus slave and vector presentation of the interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module vpic_top
(
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Avalon-MM register slave.
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Request sources.
   input wire logic [vpic_pkg::NUM_SRC-1:0] src_req_in,
   input wire logic [vpic_pkg::NUM_EXT-1:0] ext_pin_in,
   input wire logic [vpic_pkg::NUM_TRAPS-1:0] trap_req_in,
   // Processor core side.
   input wire logic core_ack_in,
   output logic core_req_out,
   output logic [6:0] core_vector_out,
   output logic [3:0] core_level_out,
   output logic [23:0] core_vec_addr_out,
   output logic [3:0] cpu_level_out,
   // Summary interrupt.
   output logic irq_out
);
   import vpic_pkg::*;

   typedef struct packed {
      // Bus slave.
      vpic_bus_t bus;
      logic waitreq;
      logic [31:0] rdata;
      // Software registers.
      logic [15:0] gctl1;
      logic [15:0] gctl2;
      logic [FLAG_BITS-1:0] flag;
      logic [FLAG_BITS-1:0] en;
      logic [NUM_SRC-1:0][2:0] prio;
      logic [2:0] cpu_low;
      logic cpu_top;
      logic [6:0] cap_vec;
      logic [3:0] cap_lvl;
      // Pin history and summary status.
      logic [NUM_EXT-1:0] ext_prev;
      logic [IST_W-1:0] ist;
      logic [IST_W-1:0] imask;
      // Vector presented to the core.
      logic req;
      logic [6:0] vec;
      logic [3:0] lvl;
      logic [23:0] vaddr;
      logic irq;
   } vpic_state_t;

   vpic_state_t s_q;
   vpic_state_t s_d;
   vpic_arb_if arb_bus();

   // Bus strobes, decode helpers and arbitration results.
   logic acc_rd;
   logic acc_wr;
   logic [7:0] rel;
   logic [5:0] widx;
   logic [FLAG_BITS-1:0] flag_set;
   logic [NUM_TRAPS-1:0] trap_set;
   logic [15:0] wd;
   logic [31:0] rd;
   logic take_trap;
   logic take_user;
   logic [6:0] pick_vec;
   logic [3:0] pick_lvl;
   logic ext_edge;

   // Encoders see the live register state.
   assign arb_bus.flag = s_q.flag[NUM_SRC-1:0];
   assign arb_bus.en = s_q.en[NUM_SRC-1:0];
   assign arb_bus.prio = s_q.prio;
   assign arb_bus.cpu_level = {s_q.cpu_top, s_q.cpu_low};
   // Trap flags live in the first global register; reserved slots never raise one.
   always_comb
   begin
      for (int t = 0; t < NUM_TRAPS; t++)
      begin
         arb_bus.trap_flag[t] = TRAP_SLOT_MASK[t] && s_q.gctl1[TRAP_FLAG_BIT[t]];
      end
   end

   // The encoders are pure logic; their results are registered with the rest of the state.
   vpic_user_arb u_user_arb
   (
      .bus(arb_bus.arb)
   );

   vpic_trap_arb u_trap_arb
   (
      .bus(arb_bus.trap)
   );

   // Request events: peripheral inputs plus selected edges on the external pins.
   always_comb
   begin
      flag_set = '0;
      flag_set[NUM_SRC-1:0] = src_req_in;
      for (int e = 0; e < NUM_EXT; e++)
      begin
         // A set polarity bit chooses the falling edge instead of the rising one.
         ext_edge = s_q.gctl2[e] ? (s_q.ext_prev[e] && !ext_pin_in[e])
            : (!s_q.ext_prev[e] && ext_pin_in[e]);
         flag_set[EXT_SRC[e]] = flag_set[EXT_SRC[e]] | ext_edge;
      end
      trap_set = trap_req_in & TRAP_SLOT_MASK;
   end

   // Traps beat user requests; a trap is never gated by the enable or flag registers.
   always_comb
   begin
      take_trap = arb_bus.trap_found && (arb_bus.trap_lvl > {s_q.cpu_top, s_q.cpu_low});
      take_user = !take_trap && arb_bus.usr_found;
      pick_vec = take_trap ? {4'h0, arb_bus.trap_slot} : (arb_bus.usr_irq + USER_VEC_OFS);
      pick_lvl = take_trap ? arb_bus.trap_lvl : {1'b0, arb_bus.usr_lvl};
   end

   // Read mux; unmapped offsets and unused bits answer zero.
   always_comb
   begin
      rd = 32'h0000_0000;
      rel = 8'h00;
      if (avs_address_in == OFS_GCTL1)
      begin
         rd[15:0] = s_q.gctl1;
      end
      else if (avs_address_in == OFS_GCTL2)
      begin
         rd[15:0] = s_q.gctl2;
      end
      else if (avs_address_in >= OFS_FLAG0 && avs_address_in < OFS_FLAG0 + 8'(4 * NUM_FLAG_REGS))
      begin
         rel = avs_address_in - OFS_FLAG0;
         rd[15:0] = s_q.flag[16 * rel[7:2] +: 16];
      end
      else if (avs_address_in >= OFS_EN0 && avs_address_in < OFS_EN0 + 8'(4 * NUM_FLAG_REGS))
      begin
         rel = avs_address_in - OFS_EN0;
         rd[15:0] = s_q.en[16 * rel[7:2] +: 16];
      end
      else if (avs_address_in >= OFS_PRIO0 && avs_address_in < OFS_PRIO0 + 8'(4 * NUM_PRIO_REGS))
      begin
         rel = avs_address_in - OFS_PRIO0;
         // Four three-bit fields per word, one to a nibble.
         for (int f = 0; f < 4; f++)
         begin
            rd[4 * f +: 3] = s_q.prio[4 * rel[7:2] + f];
         end
      end
      else if (avs_address_in == OFS_CAPTURE)
      begin
         rd[6:0] = s_q.cap_vec;
         rd[CAP_LVL_LSB +: 4] = s_q.cap_lvl;
      end
      else if (avs_address_in == OFS_CPU_STATUS)
      begin
         rd[CPU_LOW_LSB +: 3] = s_q.cpu_low;
      end
      else if (avs_address_in == OFS_CORE_CTRL)
      begin
         rd[CPU_TOP_BIT] = s_q.cpu_top;
      end
      else if (avs_address_in == OFS_IRQ_STAT)
      begin
         rd[IST_W-1:0] = s_q.ist;
      end
      else if (avs_address_in == OFS_IRQ_MASK)
      begin
         rd[IST_W-1:0] = s_q.imask;
      end
   end

   // Next state: bus handshake, register writes, hardware sets and vector presentation.
   always_comb
   begin
      s_d = s_q;
      wd = avs_writedata_in[15:0];
      widx = 6'h00;
      acc_rd = 1'b0;
      acc_wr = 1'b0;
      // One wait cycle per access keeps read data coming straight from a flip-flop.
      case (s_q.bus)
         VPIC_BUS_IDLE:
         begin
            if (avs_read_in || avs_write_in)
            begin
               s_d.bus = VPIC_BUS_ACK;
               s_d.waitreq = 1'b0;
               s_d.rdata = avs_read_in ? rd : 32'h0000_0000;
            end
         end
         VPIC_BUS_ACK:
         begin
            // The access completes on this edge, which the master samples.
            s_d.bus = VPIC_BUS_IDLE;
            s_d.waitreq = 1'b1;
            acc_rd = avs_read_in;
            acc_wr = avs_write_in;
         end
         default:
         begin
            s_d.bus = VPIC_BUS_IDLE;
            s_d.waitreq = 1'b1;
         end
      endcase
      // Software writes land on the edge that ends the wait.
      if (acc_wr)
      begin
         if (avs_address_in == OFS_GCTL1)
         begin
            // Software may clear trap flags; a trap in the same cycle sets them again below.
            s_d.gctl1 = wd & GCTL1_WMASK;
         end
         else if (avs_address_in == OFS_GCTL2)
         begin
            s_d.gctl2 = wd & GCTL2_WMASK;
         end
         else if (avs_address_in >= OFS_FLAG0
            && avs_address_in < OFS_FLAG0 + 8'(4 * NUM_FLAG_REGS))
         begin
            widx = 6'(avs_address_in - OFS_FLAG0 >> 2);
            // Writing a one sets a flag as well; hardware sets are merged in afterwards.
            s_d.flag[16 * widx +: 16] = wd;
         end
         else if (avs_address_in >= OFS_EN0 && avs_address_in < OFS_EN0 + 8'(4 * NUM_FLAG_REGS))
         begin
            widx = 6'(avs_address_in - OFS_EN0 >> 2);
            s_d.en[16 * widx +: 16] = wd;
         end
         else if (avs_address_in >= OFS_PRIO0
            && avs_address_in < OFS_PRIO0 + 8'(4 * NUM_PRIO_REGS))
         begin
            widx = 6'(avs_address_in - OFS_PRIO0 >> 2);
            for (int f = 0; f < 4; f++)
            begin
               s_d.prio[4 * widx + f] = wd[4 * f +: 3];
            end
         end
         else if (avs_address_in == OFS_CPU_STATUS)
         begin
            // With nesting disabled a write leaves the level bits as they are.
            if (!s_q.gctl1[NEST_DIS_BIT])
            begin
               s_d.cpu_low = wd[CPU_LOW_LSB +: 3];
            end
         end
         else if (avs_address_in == OFS_CORE_CTRL)
         begin
            // Clear-only from software, so only a taken trap sets the top level bit.
            s_d.cpu_top = s_q.cpu_top & wd[CPU_TOP_BIT];
         end
         else if (avs_address_in == OFS_IRQ_MASK)
         begin
            // Mask bits follow the layout of the status bits.
            s_d.imask = wd[IST_W-1:0];
         end
      end
      // Reading the status register clears it.
      if (acc_rd && avs_address_in == OFS_IRQ_STAT)
      begin
         s_d.ist = '0;
      end
      // Hardware sets come after software clears so a same-cycle event survives.
      s_d.flag = s_d.flag | flag_set;
      // Bits above the last request number do not exist and read as zero.
      s_d.flag[FLAG_BITS-1:NUM_SRC] = '0;
      s_d.en[FLAG_BITS-1:NUM_SRC] = '0;
      for (int t = 0; t < NUM_TRAPS; t++)
      begin
         if (trap_set[t])
         begin
            s_d.gctl1[TRAP_FLAG_BIT[t]] = 1'b1;
         end
      end
      // Pin history follows the pins every cycle, so a polarity change makes no edge.
      s_d.ext_prev = ext_pin_in;
      // Present the winner and latch it as the pending capture.
      s_d.req = take_trap || take_user;
      if (take_trap || take_user)
      begin
         s_d.vec = pick_vec;
         s_d.lvl = pick_lvl;
         s_d.cap_vec = pick_vec;
         s_d.cap_lvl = pick_lvl;
         s_d.vaddr = (s_q.gctl2[ALT_SEL_BIT] ? ALTERNATE_BASE : PRIMARY_BASE)
            + 24'(VEC_STRIDE) * {17'h00000, pick_vec};
      end
      // The core taking a vector raises the CPU level to the vector's level.
      // It wins over a software write of the level in the same cycle.
      if (core_ack_in && s_q.req)
      begin
         s_d.cpu_top = s_q.lvl[3];
         s_d.cpu_low = s_q.lvl[2:0];
         s_d.req = 1'b0;
      end
      // Status bits are set after the read clear, so an event in that cycle survives.
      if (trap_set != '0)
      begin
         s_d.ist[IST_TRAP] = 1'b1;
      end
      if (take_user && !s_q.req)
      begin
         s_d.ist[IST_USER] = 1'b1;
      end
      s_d.irq = (s_d.ist & s_d.imask) != '0;
   end

   // Single state register; reset clears every field except the bus state, which goes idle, and waitrequest, which goes high.
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         s_q <= '0;
         s_q.bus <= VPIC_BUS_IDLE;
         s_q.waitreq <= 1'b1;
         s_q.gctl1 <= GCTL_RESET;
         s_q.gctl2 <= GCTL_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register.
   assign avs_readdata_out = s_q.rdata;
   assign avs_waitrequest_out = s_q.waitreq;
   assign core_req_out = s_q.req;
   assign core_vector_out = s_q.vec;
   assign core_level_out = s_q.lvl;
   assign core_vec_addr_out = s_q.vaddr;
   assign cpu_level_out = {s_q.cpu_top, s_q.cpu_low};
   assign irq_out = s_q.irq;
endmodule
`default_nettype wire

// >>> verilog/vpic_pkg.sv
// Package of constants and types for the vectored priority interrupt controller.
package vpic_pkg;
   // Source and register counts.
   localparam int NUM_SRC = 72;
   localparam int NUM_FLAG_REGS = 5;
   localparam int NUM_PRIO_REGS = 18;
   localparam int NUM_TRAPS = 8;
   localparam int NUM_EXT = 5;
   localparam int FLAG_BITS = 16 * NUM_FLAG_REGS;
   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_GCTL1 = 8'h00;
   localparam logic [7:0] OFS_GCTL2 = 8'h04;
   localparam logic [7:0] OFS_FLAG0 = 8'h08;
   localparam logic [7:0] OFS_EN0 = 8'h20;
   localparam logic [7:0] OFS_PRIO0 = 8'h40;
   localparam logic [7:0] OFS_CAPTURE = 8'h90;
   localparam logic [7:0] OFS_CPU_STATUS = 8'h94;
   localparam logic [7:0] OFS_CORE_CTRL = 8'h98;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h9C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'hA0;
   // Field positions and writable masks.
   localparam int NEST_DIS_BIT = 15;
   localparam int ALT_SEL_BIT = 15;
   localparam int CPU_LOW_LSB = 5;
   localparam int CPU_TOP_BIT = 3;
   localparam int CAP_LVL_LSB = 8;
   localparam logic [15:0] GCTL1_WMASK = 16'hFFFE;
   localparam logic [15:0] GCTL2_WMASK = 16'h801F;
   localparam logic [15:0] GCTL_RESET = 16'h0000;
   // Trap slot to trap flag bit in the first global register; zero marks a reserved slot.
   localparam int TRAP_FLAG_BIT [NUM_TRAPS] = '{0, 1, 3, 2, 4, 5, 0, 0};
   localparam logic [7:0] TRAP_SLOT_MASK = 8'h3E;
   localparam logic [3:0] TRAP_LVL_TOP = 4'hF;
   // Request numbers of the external pins, in pin order.
   localparam int EXT_SRC [NUM_EXT] = '{0, 20, 29, 53, 54};
   // Vector numbering and table addresses.
   localparam logic [6:0] USER_VEC_OFS = 7'h08;
   localparam logic [23:0] PRIMARY_BASE = 24'h000004;
   localparam logic [23:0] ALTERNATE_BASE = 24'h000104;
   localparam int VEC_STRIDE = 2;
   // Interrupt status bit positions.
   localparam int IST_TRAP = 0;
   localparam int IST_USER = 1;
   localparam int IST_W = 2;
   // Bus handshake states.
   typedef enum logic [1:0] {
      VPIC_BUS_IDLE = 2'b01,
      VPIC_BUS_ACK = 2'b10
   } vpic_bus_t;
endpackage

// >>> verilog/vpic_arb_if.sv
// Interface between the register core and its two priority encoders.
`timescale 1ns/10ps
`default_nettype none
interface vpic_arb_if;
   import vpic_pkg::*;
   logic [NUM_SRC-1:0] flag;
   logic [NUM_SRC-1:0] en;
   logic [NUM_SRC-1:0][2:0] prio;
   logic [3:0] cpu_level;
   logic usr_found;
   logic [6:0] usr_irq;
   logic [2:0] usr_lvl;
   logic [NUM_TRAPS-1:0] trap_flag;
   logic trap_found;
   logic [2:0] trap_slot;
   logic [3:0] trap_lvl;
   modport ctl(output flag, en, prio, cpu_level, trap_flag,
      input usr_found, usr_irq, usr_lvl, trap_found, trap_slot, trap_lvl);
   modport arb(input flag, en, prio, cpu_level, output usr_found, usr_irq, usr_lvl);
   modport trap(input trap_flag, output trap_found, trap_slot, trap_lvl);
endinterface
`default_nettype wire

// >>> verilog/vpic_user_arb.sv
// Picks the winning user request by programmed and then natural priority.
`timescale 1ns/10ps
`default_nettype none
module vpic_user_arb
(
   // Encoder connection.
   vpic_arb_if.arb bus
);
   import vpic_pkg::*;

   logic blocked;

   // Ascending scan with a strict compare keeps the lowest request on a tie.
   always_comb
   begin
      blocked = bus.cpu_level[3] || (bus.cpu_level[2:0] == 3'h7);
      bus.usr_found = 1'b0;
      bus.usr_irq = 7'h00;
      bus.usr_lvl = 3'h0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (!blocked && bus.flag[i] && bus.en[i] && ({1'b0, bus.prio[i]} > bus.cpu_level)
            && (!bus.usr_found || bus.prio[i] > bus.usr_lvl))
         begin
            bus.usr_found = 1'b1;
            bus.usr_irq = 7'(i);
            bus.usr_lvl = bus.prio[i];
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/vpic_trap_arb.sv
// Picks the pending trap of lowest slot and gives its fixed level.
`timescale 1ns/10ps
`default_nettype none
module vpic_trap_arb
(
   // Encoder connection.
   vpic_arb_if.trap bus
);
   import vpic_pkg::*;

   // Descending scan so the lowest pending slot is the last one taken.
   always_comb
   begin
      bus.trap_found = 1'b0;
      bus.trap_slot = 3'h0;
      bus.trap_lvl = 4'h0;
      for (int i = NUM_TRAPS - 1; i >= 0; i--)
      begin
         if (bus.trap_flag[i] && TRAP_SLOT_MASK[i])
         begin
            bus.trap_found = 1'b1;
            bus.trap_slot = 3'(i);
            bus.trap_lvl = TRAP_LVL_TOP - 4'(i);
         end
      end
   end
endmodule
`default_nettype wire

// >>> dv/vpic_top_sva.sv
// Port-level assertions for the vectored priority interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module vpic_top_sva
(
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Register bus handshake.
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   // Processor core side.
   input wire logic core_ack_in,
   input wire logic core_req_out,
   input wire logic [6:0] core_vector_out,
   input wire logic [3:0] core_level_out,
   input wire logic [23:0] core_vec_addr_out,
   input wire logic [3:0] cpu_level_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // A request seen by an idle slave, and a vector taken by the core.
   sequence s_taken;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_ack;
      core_req_out && core_ack_in;
   endsequence
   bus_answer_a: assert property (s_taken |=> !avs_waitrequest_out)
      else $error("Bus request not answered after one wait.");
   wait_pulse_a: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
      else $error("Waitrequest low for more than one cycle.");
   addr_map_a: assert property (core_req_out |-> core_vector_out < 7'h50 &&
      core_vec_addr_out[7:0] == 8'h04 + {core_vector_out, 1'b0} && core_vec_addr_out[23:9] == 15'h0)
      else $error("Vector address does not match the vector number.");
   trap_level_a: assert property (core_req_out && core_vector_out < 7'h08 |->
      core_vector_out inside {[1:5]} && core_level_out == 4'hF - core_vector_out[3:0])
      else $error("Trap slot or level wrong.");
   // The level is held for one cycle first, because the request lags a level change by one edge.
   user_above_a: assert property (core_req_out && core_vector_out >= 7'h08 &&
      $stable(cpu_level_out) |-> core_level_out > cpu_level_out && cpu_level_out < 4'h7)
      else $error("User vector presented at or below the CPU level.");
   ack_level_a: assert property (s_ack |=> cpu_level_out == $past(core_level_out))
      else $error("CPU level not taken from the acknowledged vector.");
   top_bit_a: assert property ($rose(cpu_level_out[3]) |->
      $past(core_ack_in && core_req_out && core_level_out[3]))
      else $error("Top CPU level bit set without a taken trap.");
   reset_clear_a: assert property ($past(rst_in) |-> cpu_level_out == 4'h0 && !core_req_out)
      else $error("CPU level or request not clear after reset.");
endmodule
bind vpic_top vpic_top_sva u_sva(.clk_sys_in(clk_sys_in), .rst_in(rst_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_waitrequest_out(avs_waitrequest_out), .core_ack_in(core_ack_in),
   .core_req_out(core_req_out), .core_vector_out(core_vector_out),
   .core_level_out(core_level_out), .core_vec_addr_out(core_vec_addr_out),
   .cpu_level_out(cpu_level_out));
`default_nettype wire

// >>> dv/vpic_core_model.sv
// Behavioural processor core that takes presented vectors after a set latency.
`timescale 1ns/10ps
`default_nettype none
module vpic_core_model
#(
   parameter int LAT = 2
)
(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Vector handshake.
   input wire logic req_in,
   input wire logic ack_en_in,
   output logic ack_out
);
   int cnt = 0;
   // A slow core: it waits LAT cycles of a standing request and never acks twice in a row.
   always @(posedge clk_in)
   begin
      if (rst_in || !req_in || ack_out)
         cnt <= 0;
      else
         cnt <= cnt + 1;
      ack_out <= !rst_in && ack_en_in && req_in && !ack_out && cnt >= LAT;
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking testbench for the vectored priority interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import vpic_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] d;
   logic wait_r;
   logic [NUM_SRC-1:0] src = '0;
   logic [NUM_TRAPS-1:0] trap = '0;
   logic [NUM_EXT-1:0] ext = '0;
   logic ack_en = 1'b0;
   logic ack;
   logic req;
   logic [6:0] vec;
   logic [3:0] lvl;
   logic [23:0] vaddr;
   logic [3:0] cpu;
   logic irq;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   // Clock of 4 ns.
   always #2 clk_sys_in = ~clk_sys_in;
   vpic_top DUT(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(addr),
      .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .src_req_in(src),
      .ext_pin_in(ext), .trap_req_in(trap), .core_ack_in(ack), .core_req_out(req),
      .core_vector_out(vec), .core_level_out(lvl), .core_vec_addr_out(vaddr),
      .cpu_level_out(cpu), .irq_out(irq));
   vpic_core_model u_core(.clk_in(clk_sys_in), .rst_in(rst_in), .req_in(req),
      .ack_en_in(ack_en), .ack_out(ack));
   task stop_test;
      $display("Checks %0d, errors %0d.", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One Avalon access; the request stands until waitrequest is sampled low.
   task bus(input logic w, input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= {16'h0000, v};
      wr_en <= w;
      rd_en <= !w;
      do @(posedge clk_sys_in); while (wait_r !== 1'b0);
      d = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      chk(d, {16'h0000, e});
   endtask
   task settle;
      repeat (3) @(posedge clk_sys_in);
   endtask
   task core_chk(input logic [6:0] v, input logic [3:0] l, input logic [23:0] ad);
      chk(32'({req, lvl, vec}), {20'h0, 1'b1, l, v});
      chk(32'(vaddr), {8'h00, ad});
   endtask
   // A hang counts as a mismatch and ends the run.
   always @(posedge clk_sys_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         stop_test;
      end
   end
   // Main sequence.
   initial
   begin
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      rdc(OFS_CPU_STATUS, 16'h0000);
      bus(1'b1, 8'h18, 16'hFFFF);
      rdc(8'h18, 16'h00FF);
      bus(1'b1, 8'h18, 16'h0000);
      rdc(8'h18, 16'h0000);
      rdc(8'hFC, 16'h0000);
      bus(1'b1, 8'h28, 16'hC000);
      bus(1'b1, 8'h6C, 16'h5500);
      @(posedge clk_sys_in) src[47:46] <= 2'b11;
      @(posedge clk_sys_in) src <= '0;
      settle;
      core_chk(7'd54, 4'h5, 24'h000070);
      rdc(OFS_CAPTURE, 16'h0536);
      rdc(8'h10, 16'hC000);
      bus(1'b1, 8'h6C, 16'h6500);
      settle;
      core_chk(7'd55, 4'h6, 24'h000072);
      bus(1'b1, OFS_GCTL2, 16'h8000);
      settle;
      core_chk(7'd55, 4'h6, 24'h000172);
      bus(1'b1, OFS_GCTL2, 16'h0000);
      bus(1'b1, OFS_CPU_STATUS, 16'h00C0);
      settle;
      chk(32'(req), 32'h0);
      rdc(OFS_CPU_STATUS, 16'h00C0);
      bus(1'b1, 8'h6C, 16'h7500);
      settle;
      core_chk(7'd55, 4'h7, 24'h000072);
      bus(1'b1, OFS_CPU_STATUS, 16'h00E0);
      settle;
      chk(32'(req), 32'h0);
      bus(1'b1, OFS_GCTL1, 16'h8000);
      bus(1'b1, OFS_CPU_STATUS, 16'h0000);
      rdc(OFS_CPU_STATUS, 16'h00E0);
      bus(1'b1, OFS_GCTL1, 16'h0000);
      bus(1'b1, OFS_CPU_STATUS, 16'h0000);
      bus(1'b1, 8'h28, 16'h4000);
      settle;
      core_chk(7'd54, 4'h5, 24'h000070);
      bus(1'b1, 8'h28, 16'h0000);
      settle;
      chk(32'(req), 32'h0);
      bus(1'b1, OFS_IRQ_MASK, 16'h0001);
      ack_en <= 1'b1;
      @(posedge clk_sys_in) trap[2] <= 1'b1;
      @(posedge clk_sys_in) trap <= '0;
      for (n = 0; n < 20 && cpu !== 4'hD; n++) @(posedge clk_sys_in);
      ack_en <= 1'b0;
      chk(32'(cpu), 32'hD);
      chk(32'(irq), 32'h1);
      rdc(OFS_CORE_CTRL, 16'h0008);
      rdc(OFS_CPU_STATUS, 16'h00A0);
      rdc(OFS_GCTL1, 16'h0008);
      rdc(OFS_IRQ_STAT, 16'h0003);
      settle;
      chk(32'(irq), 32'h0);
      bus(1'b1, OFS_GCTL1, 16'h0000);
      bus(1'b1, OFS_CORE_CTRL, 16'h0000);
      settle;
      chk(32'(cpu), 32'h5);
      bus(1'b1, OFS_CORE_CTRL, 16'h0008);
      settle;
      chk(32'(cpu), 32'h5);
      // External pins: rising edge by default, falling once the polarity bit is set.
      @(posedge clk_sys_in) ext[3] <= 1'b1;
      bus(1'b1, OFS_GCTL2, 16'h0010);
      @(posedge clk_sys_in) ext[4] <= 1'b1;
      settle;
      rdc(8'h14, 16'h0020);
      ext <= 5'h00;
      settle;
      rdc(8'h14, 16'h0060);
      // A reset in mid-run clears flags, polarity and the CPU level.
      @(posedge clk_sys_in) rst_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      chk(32'(cpu), 32'h0);
      rdc(8'h14, 16'h0000);
      rdc(OFS_GCTL2, 16'h0000);
      stop_test;
   end
endmodule
`default_nettype wire
